// file: common/udw_pkg.sv
// shared constants and types for the ultra dma write burst host engine
package udw_pkg;
   localparam int          UDW_DATA_W      = 16;
   localparam logic [15:0] UDW_CRC_SEED    = 16'hffff;
   localparam logic [15:0] UDW_CRC_POLY    = 16'h1021;
   localparam logic        UDW_STROBE_IDLE = 1'b1;
   localparam logic        UDW_STOP_IDLE   = 1'b1;
   localparam logic [15:0] UDW_DATA_RST    = 16'h0000;

   // burst sequencer states, system clock side
   typedef enum logic [3:0] {
      UDW_IDLE,
      UDW_ACK,
      UDW_STOP_REL,
      UDW_XFER,
      UDW_DRAIN,
      UDW_TERM_STOP,
      UDW_CRC_SEND,
      UDW_CRC_WAIT,
      UDW_DROP
   } udw_state_t;
endpackage : udw_pkg

// file: hdl/udw_host.sv
// host side ultra dma write burst engine with link clock strobe stage
`timescale 1ns/10ps
// Contract
// R1: drive requests burst by raising its request
// R2: acknowledge only when host ready to burst
// R3: drive raises ready after host releases stop
// R4: first word on data lines before strobe
// R5: every strobe edge carries one word
// R6: no strobes while drive ready is low; code stops new words on synced ready, but a word in flight still strobes
// R7: host pauses by holding strobe steady
// R8: drive ending starts with ready dropping
// R9: host halts strobe when ready drops
// R10: drive drops request, host answers with stop
// R11: host ending: halt strobe, assert stop
// R12: drive drops request and ready after stop
// R13: strobe high, then crc on data lines
// R14: drop acknowledge with crc on lines
// R15: each edge latches one 16-bit word
// R16: termination begins on stop or request drop
// R17: lines revert to idle meanings after burst
// R18: crc covers exactly the strobed words
// R19: drive inputs synchronised before use
module udw_host #(
   parameter int DATA_W = udw_pkg::UDW_DATA_W
) (
   // system clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // link clock for strobe and data pins
   input  wire logic              link_clk,
   // drive side pins
   input  wire logic              drive_dma_request,
   input  wire logic              drive_ready,
   output logic                   host_dma_acknowledge,
   output logic                   host_stop,
   output logic                   host_strobe,
   output logic [DATA_W-1:0]      dd_out,
   output logic                   dd_oe_n,
   // user side
   input  wire logic              xfer_enable,
   input  wire logic              host_stop_req,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_valid,
   output logic                   wr_ready,
   output logic                   burst_active,
   output logic                   burst_done
);
   import udw_pkg::*;

   // crc step over one word, msb first
   function automatic logic [15:0] udw_crc_step(
      input logic [15:0]       crc,
      input logic [DATA_W-1:0] word
   );
      logic [15:0] c;
      c = crc;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         if (c[15] ^ word[i]) begin
            c = {c[14:0], 1'b0} ^ UDW_CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction : udw_crc_step

   // ---------------- system clock domain ----------------
   udw_state_t        state_reg, state_next;
   logic              dmarq_s1_reg, dmarq_s2_reg;
   logic              rdy_s1_reg, rdy_s2_reg;
   logic              ack_s1_reg, ack_s2_reg;
   logic              req_tgl_reg;
   logic              kind_crc_reg;
   logic [DATA_W-1:0] hold_reg;
   logic [15:0]       crc_reg;
   logic              dmack_reg;
   logic              stop_reg;
   logic              done_reg;
   // driven in the link domain, read here only through ack_s1/ack_s2
   logic              link_ack_tgl_reg;

   // drive inputs pass two flip-flops before use
   always_ff @(posedge clk or posedge rst) begin // see R19
      if (rst) begin
         dmarq_s1_reg <= 1'b0;
         dmarq_s2_reg <= 1'b0;
         rdy_s1_reg   <= 1'b0;
         rdy_s2_reg   <= 1'b0;
         ack_s1_reg   <= 1'b0;
         ack_s2_reg   <= 1'b0;
      end else begin
         dmarq_s1_reg <= drive_dma_request;
         dmarq_s2_reg <= dmarq_s1_reg;
         rdy_s1_reg   <= drive_ready;
         rdy_s2_reg   <= rdy_s1_reg;
         ack_s1_reg   <= link_ack_tgl_reg;
         ack_s2_reg   <= ack_s1_reg;
      end
   end

   wire link_busy  = (req_tgl_reg != ack_s2_reg);
   // a word goes out only while the drive is ready and link is idle
   wire word_go    = (state_reg == UDW_XFER) && wr_valid && rdy_s2_reg &&
                     dmarq_s2_reg && !host_stop_req && !link_busy; // see R6
   wire crc_go     = (state_reg == UDW_CRC_SEND) && !link_busy;
   wire term_cause = !dmarq_s2_reg || host_stop_req; // see R16
   wire drive_gone = !dmarq_s2_reg && !rdy_s2_reg; // see R12

   assign wr_ready     = word_go;
   assign burst_active = dmack_reg;
   assign burst_done   = done_reg;
   assign host_dma_acknowledge = dmack_reg;
   assign host_stop    = stop_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         UDW_IDLE: begin
            if (dmarq_s2_reg && xfer_enable) begin // see R1, R2
               state_next = UDW_ACK;
            end
         end
         UDW_ACK: begin
            state_next = term_cause ? UDW_TERM_STOP : UDW_STOP_REL;
         end
         UDW_STOP_REL: begin
            if (term_cause) begin
               state_next = UDW_TERM_STOP;
            end else if (rdy_s2_reg) begin // see R3
               state_next = UDW_XFER;
            end
         end
         UDW_XFER: begin
            // pausing is simply not issuing words, strobe holds level
            if (term_cause) begin // see R7, R9, R11
               state_next = UDW_DRAIN;
            end
         end
         UDW_DRAIN: begin
            if (!link_busy) begin
               state_next = UDW_TERM_STOP;
            end
         end
         UDW_TERM_STOP: begin
            if (drive_gone) begin
               state_next = UDW_CRC_SEND;
            end
         end
         UDW_CRC_SEND: begin
            if (crc_go) begin
               state_next = UDW_CRC_WAIT;
            end
         end
         UDW_CRC_WAIT: begin
            if (!link_busy) begin
               state_next = UDW_DROP;
            end
         end
         UDW_DROP: begin
            state_next = UDW_IDLE;
         end
         default: begin
            state_next = UDW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= UDW_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // acknowledge and stop outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dmack_reg <= 1'b0;
         stop_reg  <= UDW_STOP_IDLE;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= (state_reg == UDW_DROP);
         if (state_reg == UDW_IDLE && state_next == UDW_ACK) begin
            dmack_reg <= 1'b1; // see R2
         end else if (state_reg == UDW_DROP) begin
            dmack_reg <= 1'b0; // see R14
         end
         if (state_reg == UDW_ACK && state_next == UDW_STOP_REL) begin
            stop_reg <= 1'b0;
         end else if (state_reg == UDW_TERM_STOP) begin
            stop_reg <= 1'b1; // see R10, R11
         end
      end
   end

   // word handoff and running crc
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_tgl_reg  <= 1'b0;
         kind_crc_reg <= 1'b0;
         hold_reg     <= UDW_DATA_RST;
         crc_reg      <= UDW_CRC_SEED;
      end else begin
         if (state_reg == UDW_IDLE) begin
            crc_reg <= UDW_CRC_SEED; // see R18
         end
         if (word_go) begin
            hold_reg     <= wr_data;
            kind_crc_reg <= 1'b0;
            req_tgl_reg  <= ~req_tgl_reg;
            crc_reg      <= udw_crc_step(crc_reg, wr_data); // see R18
         end else if (crc_go) begin
            hold_reg     <= crc_reg[DATA_W-1:0]; // see R13
            kind_crc_reg <= 1'b1;
            req_tgl_reg  <= ~req_tgl_reg;
         end
      end
   end

   // ---------------- link clock domain ----------------
   logic              link_rst_s1_reg, link_rst_reg;
   logic              req_s1_reg, req_s2_reg, req_s3_reg;
   logic              act_s1_reg, act_s2_reg;
   logic              kind_s1_reg, kind_s2_reg;
   logic              pend_reg;
   logic              strobe_reg;
   logic [DATA_W-1:0] dd_reg;
   logic              oe_n_reg;

   // hold_reg and kind stay still while a request is outstanding
   wire new_req = (req_s2_reg != req_s3_reg);

   // reset leaves the link domain only on a link clock edge
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         link_rst_s1_reg <= 1'b1;
         link_rst_reg    <= 1'b1;
      end else begin
         link_rst_s1_reg <= 1'b0;
         link_rst_reg    <= link_rst_s1_reg;
      end
   end

   always_ff @(posedge link_clk or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         req_s1_reg  <= 1'b0;
         req_s2_reg  <= 1'b0;
         req_s3_reg  <= 1'b0;
         act_s1_reg  <= 1'b0;
         act_s2_reg  <= 1'b0;
         kind_s1_reg <= 1'b0;
         kind_s2_reg <= 1'b0;
      end else begin
         req_s1_reg  <= req_tgl_reg;
         req_s2_reg  <= req_s1_reg;
         req_s3_reg  <= req_s2_reg;
         act_s1_reg  <= dmack_reg;
         act_s2_reg  <= act_s1_reg;
         kind_s1_reg <= kind_crc_reg;
         kind_s2_reg <= kind_s1_reg;
      end
   end

   // words: data first, strobe one link edge later, acknowledge back on that same edge
   // crc: strobe forced high first, crc on the lines one edge later
   always_ff @(posedge link_clk or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         pend_reg         <= 1'b0;
         link_ack_tgl_reg <= 1'b0;
         strobe_reg       <= UDW_STROBE_IDLE;
         dd_reg           <= UDW_DATA_RST;
      end else begin
         if (new_req) begin
            pend_reg <= 1'b1;
            if (kind_s2_reg) begin
               strobe_reg <= 1'b1; // see R13
            end else begin
               dd_reg <= hold_reg; // see R4, R15
            end
         end else if (pend_reg) begin
            pend_reg         <= 1'b0;
            link_ack_tgl_reg <= ~link_ack_tgl_reg;
            if (kind_s2_reg) begin
               dd_reg <= hold_reg; // see R13
            end else begin
               strobe_reg <= ~strobe_reg; // see R5
            end
         end else if (!act_s2_reg) begin
            strobe_reg <= UDW_STROBE_IDLE; // see R17
         end
      end
   end

   // data lines released outside a burst
   always_ff @(posedge link_clk or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         oe_n_reg <= 1'b1;
      end else begin
         oe_n_reg <= ~act_s2_reg; // see R17
      end
   end

   assign host_strobe = strobe_reg;
   assign dd_out      = dd_reg;
   assign dd_oe_n     = oe_n_reg;
endmodule : udw_host

// file: test/udw_chk.sv
// checker of the host burst engine ports
`timescale 1ns/10ps
module udw_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins and user side
   input wire logic drive_dma_request,
   input wire logic host_dma_acknowledge,
   input wire logic host_stop,
   input wire logic host_strobe,
   input wire logic xfer_enable,
   input wire logic wr_ready,
   input wire logic burst_active,
   input wire logic burst_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_has_cause: assert property (
      $rose(host_dma_acknowledge) |->
      $past(drive_dma_request) && $past(xfer_enable))
      else $error("ack rose without request");
   a_stop_after_ack: assert property (
      $fell(host_stop) |-> $past(host_dma_acknowledge))
      else $error("stop released before ack");
   a_stop_idle_high: assert property (
      !host_dma_acknowledge |-> host_stop)
      else $error("stop low outside burst");
   a_word_in_burst: assert property (
      wr_ready |-> host_dma_acknowledge && !host_stop)
      else $error("word taken outside transfer");
   a_stop_answers: assert property (
      $fell(drive_dma_request) && host_dma_acknowledge |->
      ##[1:80] host_stop)
      else $error("stop not asserted after request drop");
   a_strobe_high_end: assert property (
      $fell(host_dma_acknowledge) |-> host_strobe)
      else $error("strobe low at ack drop");
   a_strobe_idle: assert property (
      !host_dma_acknowledge && !drive_dma_request |-> host_strobe)
      else $error("strobe low while idle");
   a_done_after_drop: assert property (
      $fell(host_dma_acknowledge) |-> ##[0:2] burst_done)
      else $error("no done pulse");
   a_active_is_ack: assert property (
      burst_active == host_dma_acknowledge &&
      !(burst_done && host_dma_acknowledge))
      else $error("active and ack disagree");
   a_done_one_pulse: assert property (
      burst_done |-> $past(host_dma_acknowledge) && !host_dma_acknowledge)
      else $error("done pulse not right after ack drop");
   c_word: cover property (wr_ready);
   c_host_end: cover property ($rose(host_stop) && drive_dma_request);
   c_end: cover property ($fell(host_dma_acknowledge));
endmodule : udw_chk
bind udw_host udw_chk i_chk (.clk(clk), .rst(rst),
   .drive_dma_request(drive_dma_request),
   .host_dma_acknowledge(host_dma_acknowledge), .host_stop(host_stop),
   .host_strobe(host_strobe), .xfer_enable(xfer_enable),
   .wr_ready(wr_ready), .burst_active(burst_active),
   .burst_done(burst_done));

// file: test/udw_drive_model.sv
// behavioural disk drive for write bursts
`timescale 1ns/10ps
module udw_drive_model (
   // bench clock and controls
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic        drv_end,
   input  wire logic        pause,
   // host pins
   input  wire logic        host_dma_acknowledge,
   input  wire logic        host_stop,
   input  wire logic        host_strobe,
   input  wire logic [15:0] dd_out,
   output logic             drive_dma_request,
   output logic             drive_ready,
   output logic [15:0]      crc_seen
);
   logic [15:0] rx_q[$];
   int          low_cnt = 0, late = 0;
   // cycles since ready went low; well past one word in flight
   always @(posedge clk) low_cnt <= drive_ready ? 0 : low_cnt + 1;
   always @(host_strobe)
      if (!rst && host_dma_acknowledge && !host_stop) begin
         rx_q.push_back(dd_out);
         if (low_cnt > 40) late++;
      end
   always @(negedge host_dma_acknowledge)
      if (!rst) crc_seen = dd_out;
   initial begin
      drive_dma_request = 1'b0;
      drive_ready = 1'b0;
      crc_seen = 16'h0000;
      forever begin
         wait (go === 1'b1 && rst === 1'b0);
         @(posedge clk) drive_dma_request <= 1'b1;
         wait (host_dma_acknowledge === 1'b1 && host_stop === 1'b0);
         @(posedge clk);
         while (!host_stop && !drv_end) begin
            drive_ready <= !pause;
            @(posedge clk);
         end
         if (!host_stop) begin
            drive_ready <= 1'b0;
            repeat (8) @(posedge clk);
         end
         drive_dma_request <= 1'b0;
         drive_ready <= 1'b0;
         wait (host_dma_acknowledge === 1'b0);
      end
   end
endmodule : udw_drive_model

// file: test/udw_host_test.sv
// testbench of the host write burst engine
`timescale 1ns/10ps
module udw_host_test;
   import udw_pkg::*;
   logic        clk = 0, rst = 1, link_clk = 0, xfer_enable = 1;
   logic        host_stop_req = 0, wr_valid = 0, go = 0, drv_end = 0;
   logic        pause = 0, hold_pause = 0, oe_n;
   logic [15:0] wr_data = 16'h0000, crc_seen, dd_out, crc_exp;
   logic        req, rdy, ack, stop, strobe, wr_ready, burst_done;
   logic [15:0] sent[$];
   logic [31:0] rnd = 32'h2d942460;
   int          fails = 0, checked = 0;
   udw_host i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
      .drive_dma_request(req), .drive_ready(rdy),
      .host_dma_acknowledge(ack), .host_stop(stop), .host_strobe(strobe),
      .dd_out(dd_out), .dd_oe_n(oe_n), .xfer_enable(xfer_enable),
      .host_stop_req(host_stop_req), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .burst_active(),
      .burst_done(burst_done));
   udw_drive_model i_drv (.clk(clk), .rst(rst), .go(go),
      .drv_end(drv_end), .pause(pause), .host_dma_acknowledge(ack),
      .host_stop(stop), .host_strobe(strobe), .dd_out(dd_out),
      .drive_dma_request(req), .drive_ready(rdy), .crc_seen(crc_seen));
   function logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function logic [15:0] crc_next(logic [15:0] c, logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? UDW_CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_next
   task chk(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task run(input logic by_drv);
      int i;
      sent.delete();
      i_drv.rx_q.delete();
      go <= 1'b1;
      for (i = 0; ack !== 1'b1 && i < 200; i++) @(negedge clk);
      chk("ack", {15'h0000, ack}, 16'h0001);
      @(posedge clk) go <= 1'b0;
      repeat (150) @(posedge clk);
      chk("oe_n_burst", {15'h0000, oe_n}, 16'h0000);
      hold_pause <= 1'b1;
      repeat (100) @(posedge clk);
      hold_pause <= 1'b0;
      repeat (50) @(posedge clk);
      if (by_drv) drv_end <= 1'b1;
      else host_stop_req <= 1'b1;
      for (i = 0; burst_done !== 1'b1 && i < 3000; i++) @(negedge clk);
      chk("burst_done", {15'h0000, burst_done}, 16'h0001);
      @(posedge clk) drv_end <= 1'b0;
      host_stop_req <= 1'b0;
      crc_exp = UDW_CRC_SEED;
      foreach (sent[k]) crc_exp = crc_next(crc_exp, sent[k]);
      chk("count", 16'(i_drv.rx_q.size()), 16'(sent.size()));
      foreach (sent[k])
         if (k < i_drv.rx_q.size())
            chk("word", i_drv.rx_q[k], sent[k]);
      chk("crc", crc_seen, crc_exp);
      chk("late_strobes", 16'(i_drv.late), 16'h0000);
      repeat (40) @(posedge clk);
      chk("oe_n_idle", {15'h0000, oe_n}, 16'h0001);
      $display("test done, ended by drive %0d", by_drv);
   endtask : run
   initial forever #12.5 clk = ~clk;
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end
   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      wr_valid <= rnd[3] | rnd[7];
      wr_data <= rnd[23:8];
      pause <= hold_pause | (rnd[12:10] == 3'h0);
      if (wr_valid && wr_ready) sent.push_back(wr_data);
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      xfer_enable <= 1'b0;
      go <= 1'b1;
      repeat (60) @(negedge clk);
      chk("ack_gated", {15'h0000, ack}, 16'h0000);
      @(posedge clk) xfer_enable <= 1'b1;
      for (int n = 0; n < 4; n++) run(n[0]);
      end_sim;
   end
   initial begin
      #500000;
      fails++;
      end_sim;
   end
endmodule : udw_host_test
